// ===== hw/arfcs_regs.vh
// register offsets, field positions, reset values and codes for the result/channel block
// assumes an 8-bit special-function register port with byte addresses
`ifndef ARFCS_REGS_VH
`define ARFCS_REGS_VH
// channel select register
`define ARFCS_CHAN_ADDR 8'hBB
`define ARFCS_CHAN_RESET 5'h1F
// configuration register (repeat count in bits 2..1)
`define ARFCS_CFG_ADDR 8'hBC
`define ARFCS_CFG_RESET 8'hF8
`define ARFCS_RPT_LSB 1
// control register (left justify in bit 2, done flag in bit 5)
`define ARFCS_CTL_ADDR 8'hE8
`define ARFCS_CTL_RESET 8'h00
`define ARFCS_LJ_BIT 2
`define ARFCS_DONE_BIT 5
// result bytes
`define ARFCS_RESH_ADDR 8'hBE
`define ARFCS_RESL_ADDR 8'hBD
// channel codes
`define ARFCS_CODE_LAST_PIN 5'h17
`define ARFCS_CODE_TEMP 5'h18
`define ARFCS_CODE_SUPPLY 5'h19
// mux select encodings
`define ARFCS_SEL_PIN 2'h0
`define ARFCS_SEL_TEMP 2'h1
`define ARFCS_SEL_SUPPLY 2'h2
`define ARFCS_SEL_GND 2'h3
`endif

// ===== hw/arfcs_accum.v
// sample accumulator: sums 1, 4, 8 or 16 twelve-bit samples
// assumes samples arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps
module arfcs_accum (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire [1:0] rpt_sel,
  input wire sample_valid,
  input wire [11:0] sample,
  output reg [15:0] sum_out,
  output reg sum_valid
);
  // running sum and count within a series
  reg [15:0] acc_reg;
  reg [3:0] cnt_reg;
  reg [3:0] last_cnt;
  wire [15:0] acc_next;

  // last index of a series for each repeat setting
  always @* begin
    case (rpt_sel)
      2'h0: last_cnt = 4'h0;
      2'h1: last_cnt = 4'h3;
      2'h2: last_cnt = 4'h7;
      default: last_cnt = 4'hF;
    endcase
  end

  assign acc_next = acc_reg + {4'h0, sample};

  // accumulate and release at series end
  always @(posedge clock) begin
    if (!rstn) begin
      acc_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      sum_out <= 16'h0000;
      sum_valid <= 1'b0;
    end else if (ce) begin
      sum_valid <= 1'b0;
      if (sample_valid) begin
        if (cnt_reg == last_cnt) begin
          sum_out <= acc_next;
          sum_valid <= 1'b1;
          acc_reg <= 16'h0000;
          cnt_reg <= 4'h0;
        end else begin
          acc_reg <= acc_next;
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule // arfcs_accum

// ===== hw/arfcs_top.v
// result formatting and input channel selection for a 12-bit converter
// assumes an 8-bit register port on the system clock and sample strobes from the converter
//
// What this block does
// - single results are 12-bit, refreshed each conversion
// - right justify to 11..0, left to 15..4
// - unused result bits always read zero
// - repeated series update only after last
// - accumulate 4, 8 or 16 samples
// - accumulated value is plain sum
// - five-bit code selects pins, temp, supply, ground
// - hardware sets done flag only after full series
`timescale 1ns/1ps
`include "arfcs_regs.vh"
module arfcs_top (
  input wire clock,
  input wire rstn,
  input wire ce,
  // register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // converter sample input
  input wire sample_valid,
  input wire [11:0] sample,
  // analog mux control
  output reg [1:0] mux_sel,
  output reg [4:0] pin_index,
  output reg [4:0] channel_code
);
  // configuration register: repeat count in bits 2..1, bit 0 reads zero
  reg [7:0] cfg_reg;
  // left justify select, honoured for single results only
  reg lj_reg;
  // conversion done flag, set by hardware, written by software
  reg done_reg;
  // result pair as software reads it
  reg [7:0] result_high_byte;
  reg [7:0] result_low_byte;
  // mux select decoded from the current channel code
  reg [1:0] sel_next;
  // pin number that goes with the decoded select
  reg [4:0] pin_next;
  // read data of the addressed register
  reg [7:0] rd_next;
  // formatted result ahead of the result bytes
  wire [15:0] fmt;
  // left justify really applied to this result
  wire lj_apply;
  // repeat count field
  wire [1:0] rpt_sel;
  // finished value and its one-cycle strobe from the accumulator
  wire [15:0] sum_out;
  wire sum_valid;
  // per-register write strobes, already gated by the clock enable
  wire wr_chan;
  wire wr_cfg;
  wire wr_ctl;
  // read strobe gated by the clock enable
  wire rd_take;
  // bit index of the justify loop
  genvar b;

  // repeat count straight from the configuration register
  assign rpt_sel = cfg_reg[`ARFCS_RPT_LSB+1:`ARFCS_RPT_LSB];

  // write and read decode; a low enable blocks every access so nothing moves
  assign wr_chan = ce && sfr_wr && (sfr_addr == `ARFCS_CHAN_ADDR);
  assign wr_cfg = ce && sfr_wr && (sfr_addr == `ARFCS_CFG_ADDR);
  assign wr_ctl = ce && sfr_wr && (sfr_addr == `ARFCS_CTL_ADDR);
  assign rd_take = ce && sfr_rd;

  // sums are defined right justified only, so the shift is kept to repeat one
  assign lj_apply = lj_reg && (rpt_sel == 2'h0);

  arfcs_accum u_accum (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .rpt_sel(rpt_sel),
    .sample_valid(sample_valid),
    .sample(sample),
    .sum_out(sum_out),
    .sum_valid(sum_valid)
  );

  // justify the finished value one bit at a time
  // a single right-justified result is at most twelve bits wide,
  // so its top four bits arrive as zero from the accumulator
  // per-bit justification
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_just
      if (b < 4) begin : g_low
        assign fmt[b] = lj_apply ? 1'b0 : sum_out[b];
      end else begin : g_high
        // shifted up by four, or straight through
        assign fmt[b] = lj_apply ? sum_out[b-4] : sum_out[b];
      end
    end
  endgenerate

  // channel code decode
  always @* begin
    // defaults: ground, no pin
    sel_next = `ARFCS_SEL_GND;
    pin_next = 5'h00;
    if (channel_code <= `ARFCS_CODE_LAST_PIN) begin
      // port pins in code order
      sel_next = `ARFCS_SEL_PIN;
      pin_next = channel_code;
    end else if (channel_code == `ARFCS_CODE_TEMP) begin
      // temperature sensor
      sel_next = `ARFCS_SEL_TEMP;
    end else if (channel_code == `ARFCS_CODE_SUPPLY) begin
      // supply rail
      sel_next = `ARFCS_SEL_SUPPLY;
    end else begin
      // every remaining code ties the input to ground
      sel_next = `ARFCS_SEL_GND;
    end
  end

  // read mux
  always @* begin
    case (sfr_addr)
      `ARFCS_CHAN_ADDR: rd_next = {3'h0, channel_code};
      `ARFCS_CFG_ADDR: rd_next = cfg_reg;
      `ARFCS_CTL_ADDR: rd_next = {2'h0, done_reg, 2'h0, lj_reg, 2'h0};
      `ARFCS_RESH_ADDR: rd_next = result_high_byte;
      `ARFCS_RESL_ADDR: rd_next = result_low_byte;
      // unmapped addresses read zero
      default: rd_next = 8'h00;
    endcase
  end

  // channel select register
  always @(posedge clock) begin
    if (!rstn) begin
      channel_code <= `ARFCS_CHAN_RESET;
    end else if (wr_chan) begin
      channel_code <= sfr_wdata[4:0];
    end
  end

  // configuration register, bit 0 kept at zero
  always @(posedge clock) begin
    if (!rstn) begin
      cfg_reg <= `ARFCS_CFG_RESET;
    end else if (wr_cfg) begin
      // changing the repeat count mid-series is left undefined
      cfg_reg <= {sfr_wdata[7:1], 1'b0};
    end
  end

  // left justify select
  always @(posedge clock) begin
    if (!rstn) begin
      lj_reg <= 1'b0;
    end else if (wr_ctl) begin
      // takes effect on the next finished result
      lj_reg <= sfr_wdata[`ARFCS_LJ_BIT];
    end
  end

  // done flag: hardware sets, software writes
  always @(posedge clock) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (ce) begin
      if (sum_valid) begin
        // done after full series
        // a clear in the same cycle loses, so no finish is missed
        done_reg <= 1'b1;
      end else if (wr_ctl) begin
        // software clear or set
        done_reg <= sfr_wdata[`ARFCS_DONE_BIT];
      end
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else if (ce && sum_valid) begin
      // both bytes from one formatted value, never torn
      result_high_byte <= fmt[15:8];
      result_low_byte <= fmt[7:0];
    end
  end

  // registered mux controls
  always @(posedge clock) begin
    if (!rstn) begin
      // ground selected out of reset
      mux_sel <= `ARFCS_SEL_GND;
      pin_index <= 5'h00;
    end else if (ce) begin
      // follow the channel code one cycle later
      mux_sel <= sel_next;
      pin_index <= pin_next;
    end
  end

  // registered read data, stands until the next read
  always @(posedge clock) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (rd_take) begin
      // sampled from the register as it stands at the read edge
      sfr_rdata <= rd_next;
    end
  end
endmodule // arfcs_top

// ===== tb/arfcs_props.sv
// checker for the channel select and mux control outputs
// sees only top ports; bound to the top below
`timescale 1ns/1ps
module arfcs_props (
  input wire clock,
  input wire rstn,
  input wire ce,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire sample_valid,
  input wire [11:0] sample,
  input wire [1:0] mux_sel,
  input wire [4:0] pin_index,
  input wire [4:0] channel_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_wr;
    ce && sfr_wr && sfr_addr == 8'hBB |=> channel_code == $past(sfr_wdata[4:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("chan write");
  property p_up; ce && sfr_rd && sfr_addr == 8'hBB |=> sfr_rdata[7:5] == 3'h0; endproperty
  a_up: assert property (p_up) else $error("chan upper");
  property p_rd;
    ce && sfr_rd && sfr_addr == 8'hBB |=> sfr_rdata[4:0] == $past(channel_code);
  endproperty
  a_rd: assert property (p_rd) else $error("chan read");
  property p_pin;
    ce && channel_code < 5'h18 |=> mux_sel == 2'h0 && pin_index == $past(channel_code);
  endproperty
  a_pin: assert property (p_pin) else $error("pin route");
  property p_tmp; ce && channel_code == 5'h18 |=> mux_sel == 2'h1; endproperty
  a_tmp: assert property (p_tmp) else $error("temp route");
  property p_sup; ce && channel_code == 5'h19 |=> mux_sel == 2'h2; endproperty
  a_sup: assert property (p_sup) else $error("supply route");
  property p_gnd; ce && channel_code > 5'h19 |=> mux_sel == 2'h3; endproperty
  a_gnd: assert property (p_gnd) else $error("ground route");
  property p_np; ce && channel_code > 5'h17 |=> pin_index == 5'h00; endproperty
  a_np: assert property (p_np) else $error("pin index");
  cover property (mux_sel == 2'h1);
  cover property (mux_sel == 2'h2);
  cover property (ce && sfr_rd && sfr_addr == 8'hBE);
  cover property (ce && sfr_wr && sfr_addr == 8'hBB && sfr_wdata[4:0] > 5'h19);
endmodule // arfcs_props
bind arfcs_top arfcs_props u_props (
  .clock(clock),
  .rstn(rstn),
  .ce(ce),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .sample_valid(sample_valid),
  .sample(sample),
  .mux_sel(mux_sel),
  .pin_index(pin_index),
  .channel_code(channel_code)
);

// ===== tb/tb.sv
// bench: channel codes, single and summed results
// drives the top ports itself, ce high but for one frozen write
`timescale 1ns/1ps
module tb;
  reg clock = 0, rstn = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, sample_valid = 0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  reg [11:0] sample = 12'h000;
  reg [15:0] prev = 16'h0FFF;
  wire [7:0] sfr_rdata;
  wire [1:0] mux_sel;
  wire [4:0] pin_index, channel_code;
  integer errors = 0, tests_run = 0, i, n;
  arfcs_top u_dut (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sample_valid(sample_valid),
    .sample(sample),
    .mux_sel(mux_sel),
    .pin_index(pin_index),
    .channel_code(channel_code)
  );
  initial forever #20 clock = ~clock;
  task end_of_test;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // count a compare, report a mismatch
  task chk(input [15:0] nm, input [15:0] e, input [15:0] s);
    begin
      tests_run = tests_run + 1;
      if (e !== s) begin
        errors = errors + 1;
        $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task cyc;
    @(posedge clock) #1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'h1;
      cyc;
      sfr_wr = 1'h0;
      cyc;
    end
  endtask
  task rd(input [15:0] nm, input [7:0] a, input [7:0] e);
    begin
      sfr_addr = a;
      sfr_rd = 1'h1;
      cyc;
      sfr_rd = 1'h0;
      chk(nm, e, sfr_rdata);
      cyc;
    end
  endtask
  // k back to back samples, then the two-edge answer
  task smp(input [11:0] v, input integer k);
    begin
      sample = v;
      sample_valid = 1'h1;
      repeat (k) cyc;
      sample_valid = 1'h0;
      repeat (2) cyc;
    end
  endtask
  task t_chan;
    begin
      rd("cr", 8'hBB, 8'h1F);
      for (i = 0; i < 32; i = i + 1) begin
        wr(8'hBB, 8'hE0 | i[4:0]);
        cyc;
        chk("ms", (i < 24) ? 0 : (i > 25) ? 3 : i - 23, mux_sel);
        chk("pi", (i < 24) ? i : 0, pin_index);
        rd("cr", 8'hBB, i);
      end
      // a write with the enable low must leave the channel as it is
      ce = 1'h0;
      wr(8'hBB, 8'h05);
      ce = 1'h1;
      rd("ce", 8'hBB, 8'h1F);
    end
  endtask
  task t_one;
    begin
      wr(8'hE8, 8'h04);
      smp(12'h801, 1);
      rd("hi", 8'hBE, 8'h80);
      rd("lo", 8'hBD, 8'h10);
      wr(8'hE8, 8'h00);
      smp(12'hFFF, 1);
      rd("hi", 8'hBE, 8'h0F);
      rd("lo", 8'hBD, 8'hFF);
      rd("dn", 8'hE8, 8'h20);
    end
  endtask
  task t_acc(input [1:0] r);
    begin
      n = 2 << r;
      wr(8'hBC, {5'h1F, r, 1'h0});
      wr(8'hE8, 8'h00);
      smp(12'hFFF, n - 1);
      rd("dn", 8'hE8, 8'h00);
      rd("hi", 8'hBE, prev[15:8]);
      smp(12'hFFF, 1);
      prev = 12'hFFF * n;
      rd("hi", 8'hBE, prev[15:8]);
      rd("lo", 8'hBD, prev[7:0]);
      rd("dn", 8'hE8, 8'h20);
    end
  endtask
  initial begin
    repeat (8) cyc;
    rstn = 1'h1;
    t_chan;
    t_one;
    for (i = 1; i < 4; i = i + 1)
      t_acc(i[1:0]);
    end_of_test;
  end
  initial begin
    #100000;
    errors = errors + 1;
    end_of_test;
  end
endmodule // tb
